// File: core/adc_pkt_ctrl.v
// converter control registers and sample packetiser with apb slave
//
// Operation
// - bit 24 of general control flags a dropped sample; a read of general control clears it.
// - results are left aligned in the chosen sample width.
// - width 0 gives 8-bit samples, low four result bits dropped; 2 reserved.
// - width 1 gives 16-bit samples, four zero bits below; reset value.
// - width 3 gives 32-bit samples, twenty zero bits below.
// - multi-byte samples leave most significant byte first.
// - packet closes after samples-per-packet count, field 15:8, reset 1.
// - count 0 keeps packet open until a per-pin or general control register access made while the sender is idle.
// - bit 1 selects internal 0.8V reference for calibration.
// - bit 0 enables converter; reset value 0.
// - while enabled, per-pin registers ignore writes.
// - first six pulses after enable make no packets; later ones deliver.
// - per-pin bit 0 enables that pin, reset 0.
// - per-pin bits 31:8 give destination channel-end, top 24 bits.
`timescale 1ns/100ps
`include "adc_pkt_map.vh"
module adc_pkt_ctrl (
    // clock and reset
    input wire mclk_in,
    input wire rstn_in,
    // apb slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    // converter side
    input wire trigger_in,
    input wire result_valid_in,
    input wire [2:0] result_pin_in,
    input wire [11:0] result_in,
    output reg conv_enable_out,
    output reg calib_ref_sel_out,
    output reg [7:0] pin_enable_out,
    // channel-end byte stream
    output reg [7:0] tx_data_out,
    output reg tx_valid_out,
    output reg tx_end_out,
    output reg [23:0] tx_dest_out,
    input wire tx_ready_in,
    // interrupt
    output reg irq_out
);
    // -----------------------------------------------------------------
    // reset synchroniser and trigger input synchroniser
    // -----------------------------------------------------------------
    reg rst_meta_q, rst_sync_q;
    reg trig_meta_q, trig_sync_q, trig_prev_q;
    wire rst_n = rst_sync_q;

    // release reset through two flip-flops
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // trigger pulse comes from outside, two stages then edge detect
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            trig_meta_q <= 1'b0;
            trig_sync_q <= 1'b0;
            trig_prev_q <= 1'b0;
        end else begin
            trig_meta_q <= trigger_in;
            trig_sync_q <= trig_meta_q;
            trig_prev_q <= trig_sync_q;
        end
    end
    wire trig_rise = trig_sync_q & ~trig_prev_q;

    // -----------------------------------------------------------------
    // apb decode
    // -----------------------------------------------------------------
    reg enable_q, calib_q, drop_q;
    reg [1:0] width_q;
    reg [7:0] spp_q;
    reg [1:0] irq_stat_q, irq_mask_q;
    reg rd_pend_q;
    reg [2:0] pend_pin_q;
    wire [31:0] mem_rd_data;
    wire [7:0] mem_pin_en;

    wire apb_setup = psel_in & ~penable_in;
    wire apb_access = psel_in & penable_in & pready_out;
    wire is_pin = (paddr_in[7:5] == 3'h0) && (paddr_in[1:0] == 2'h0);
    wire is_gen = (paddr_in == `GEN_CTRL_OFF);
    wire is_stat = (paddr_in == `IRQ_STATUS_OFF);
    wire is_mask = (paddr_in == `IRQ_MASK_OFF);
    wire mapped = is_pin | is_gen | is_stat | is_mask;
    wire wr_acc = apb_access & pwrite_in;
    wire rd_acc = apb_access & ~pwrite_in;
    wire ctrl_acc = apb_access & (is_pin | is_gen); // ends open packet

    // pin writes ignored while enabled
    wire pin_wr = wr_acc & is_pin & ~enable_q;

    pin_ctrl_mem u_mem (
        .clk_in(mclk_in),
        .rst_n_in(rst_n),
        .wr_en_in(pin_wr),
        .wr_addr_in(paddr_in[4:2]),
        .wr_data_in(pwdata_in),
        .rd_addr_in(rd_pend_q ? paddr_in[4:2] : pend_pin_q),
        .rd_data_out(mem_rd_data),
        .pin_en_out(mem_pin_en)
    );

    // -----------------------------------------------------------------
    // apb answer: setup, two wait cycles (memory read, then answer register), then ready
    // -----------------------------------------------------------------
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_q <= 1'b0;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
        end else begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            if (apb_setup) begin
                rd_pend_q <= 1'b1;
            end else if (rd_pend_q) begin
                rd_pend_q <= 1'b0;
            end
            if (psel_in && penable_in && !pready_out && !rd_pend_q) begin
                pready_out <= 1'b1;
                pslverr_out <= ~mapped;
                if (!pwrite_in) begin
                    if (is_pin) begin
                        prdata_out <= mem_rd_data;
                    end else if (is_gen) begin
                        prdata_out <= {7'h00, drop_q, 6'h00, width_q, spp_q, 6'h00, calib_q, enable_q};
                    end else if (is_stat) begin
                        prdata_out <= {30'h0, irq_stat_q};
                    end else if (is_mask) begin
                        prdata_out <= {30'h0, irq_mask_q};
                    end else begin
                        prdata_out <= 32'h0000_0000;
                    end
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // general control register
    // -----------------------------------------------------------------
    wire drop_evt;
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= 1'b0;
            calib_q <= 1'b0;
            width_q <= `GEN_WIDTH_RESET;
            spp_q <= `GEN_SPP_RESET;
            drop_q <= 1'b0;
        end else begin
            if (wr_acc && is_gen) begin
                enable_q <= pwdata_in[`GEN_ENABLE_BIT];
                calib_q <= pwdata_in[`GEN_CALIB_BIT];
                width_q <= pwdata_in[`GEN_WIDTH_MSB:`GEN_WIDTH_LSB];
                spp_q <= pwdata_in[`GEN_SPP_MSB:`GEN_SPP_LSB];
            end
            // set wins over read clear
            if (drop_evt) begin
                drop_q <= 1'b1;
            end else if (rd_acc && is_gen) begin
                drop_q <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // calibration pulse counter
    // -----------------------------------------------------------------
    reg [2:0] cal_cnt_q;
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            cal_cnt_q <= 3'h0;
        end else if (!enable_q) begin
            cal_cnt_q <= 3'h0;
        end else if (trig_rise && cal_cnt_q != `CAL_PULSES + 3'h1) begin
            cal_cnt_q <= cal_cnt_q + 3'h1;
        end
    end
    // results follow their pulse, so the sixth pulse's result is still calibration
    wire cal_done = (cal_cnt_q == `CAL_PULSES + 3'h1);

    // -----------------------------------------------------------------
    // sample capture and packet sender
    // -----------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_SEND = 2'h1;
    localparam ST_DEST = 2'h2;

    wire [31:0] fmt_word;
    wire [2:0] fmt_bytes;
    reg [1:0] state_q;
    reg [31:0] shift_q;
    reg [2:0] left_q;
    reg [7:0] cnt_q;
    reg pend_q, open_q;
    reg [11:0] pend_res_q;

    sample_format u_fmt (
        .result_in(pend_res_q),
        .width_in(width_q),
        .word_out(fmt_word),
        .nbytes_out(fmt_bytes)
    );

    // sample accepted only after calibration and for enabled pins
    wire take = result_valid_in & enable_q & cal_done & mem_pin_en[result_pin_in];
    // only the destination fetch hands the pending sample over
    assign drop_evt = take & pend_q & ~(state_q == ST_DEST);
    wire last_byte = (state_q == ST_SEND) && (left_q == 3'h1) && tx_ready_in;
    wire pkt_close = last_byte && spp_q != 8'h00 && (cnt_q + 8'h01 >= spp_q);

    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            shift_q <= 32'h0000_0000;
            left_q <= 3'h0;
            cnt_q <= 8'h00;
            pend_q <= 1'b0;
            open_q <= 1'b0;
            pend_res_q <= 12'h000;
            pend_pin_q <= 3'h0;
            tx_data_out <= 8'h00;
            tx_valid_out <= 1'b0;
            tx_end_out <= 1'b0;
            tx_dest_out <= 24'h000000;
        end else begin
            tx_end_out <= 1'b0;
            if (take && !drop_evt) begin
                pend_q <= 1'b1;
                pend_res_q <= result_in;
                pend_pin_q <= result_pin_in;
            end
            case (state_q)
                ST_IDLE: begin
                    tx_valid_out <= 1'b0;
                    if (open_q && ctrl_acc) begin
                        open_q <= 1'b0;
                        cnt_q <= 8'h00;
                        tx_end_out <= 1'b1;
                    end else if (pend_q && !rd_pend_q) begin
                        // wait while an apb transfer, read or write, owns the memory read port
                        state_q <= ST_DEST;
                    end
                end
                ST_DEST: begin
                    // memory read data now reflect the selected pin
                    tx_dest_out <= mem_rd_data[31:`PIN_DEST_LSB];
                    shift_q <= fmt_word;
                    left_q <= fmt_bytes;
                    pend_q <= take;
                    tx_data_out <= fmt_word[31:24];
                    tx_valid_out <= 1'b1;
                    open_q <= 1'b1;
                    state_q <= ST_SEND;
                end
                default: begin
                    if (tx_ready_in) begin
                        // most significant byte first
                        shift_q <= {shift_q[23:0], 8'h00};
                        tx_data_out <= shift_q[23:16];
                        left_q <= left_q - 3'h1;
                        if (left_q == 3'h1) begin
                            tx_valid_out <= 1'b0;
                            state_q <= ST_IDLE;
                            cnt_q <= pkt_close ? 8'h00 : cnt_q + 8'h01;
                            if (pkt_close) begin
                                open_q <= 1'b0;
                                tx_end_out <= 1'b1;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // interrupt status, mask and outputs
    // -----------------------------------------------------------------
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= 2'h0;
            irq_mask_q <= 2'h0;
            irq_out <= 1'b0;
            conv_enable_out <= 1'b0;
            calib_ref_sel_out <= 1'b0;
            pin_enable_out <= 8'h00;
        end else begin
            // set wins over write-one clear
            irq_stat_q[`IRQ_DROP_BIT] <= drop_evt |
                (irq_stat_q[`IRQ_DROP_BIT] & ~(wr_acc & is_stat & pwdata_in[`IRQ_DROP_BIT]));
            irq_stat_q[`IRQ_PKT_BIT] <= tx_end_out |
                (irq_stat_q[`IRQ_PKT_BIT] & ~(wr_acc & is_stat & pwdata_in[`IRQ_PKT_BIT]));
            if (wr_acc && is_mask) begin
                irq_mask_q <= pwdata_in[1:0];
            end
            irq_out <= |(irq_stat_q & irq_mask_q);
            conv_enable_out <= enable_q;
            calib_ref_sel_out <= calib_q;
            pin_enable_out <= mem_pin_en;
        end
    end
endmodule // adc_pkt_ctrl

// File: core/adc_pkt_map.vh
// register offsets, field positions, reset values and timing constants for the converter packetiser
`ifndef ADC_PKT_MAP_VH
`define ADC_PKT_MAP_VH

// register byte offsets (pin registers at 0x00..0x1c, four bytes apart)
`define PIN_CTRL_BASE 8'h00
`define GEN_CTRL_OFF 8'h20
`define IRQ_STATUS_OFF 8'h24
`define IRQ_MASK_OFF 8'h28
`define NUM_PINS 8

// general control fields
`define GEN_ENABLE_BIT 0
`define GEN_CALIB_BIT 1
`define GEN_SPP_LSB 8
`define GEN_SPP_MSB 15
`define GEN_WIDTH_LSB 16
`define GEN_WIDTH_MSB 17
`define GEN_DROP_BIT 24

// reset values
`define GEN_SPP_RESET 8'h01
`define GEN_WIDTH_RESET 2'h1

// sample width codes
`define WIDTH_8 2'h0
`define WIDTH_16 2'h1
`define WIDTH_32 2'h3

// per pin register fields
`define PIN_EN_BIT 0
`define PIN_DEST_LSB 8

// calibration pulses swallowed after enable
`define CAL_PULSES 3'h6

// interrupt status bits
`define IRQ_DROP_BIT 0
`define IRQ_PKT_BIT 1

`endif

// File: core/pin_ctrl_mem.v
// eight-word memory holding the per-pin control registers, registered read data
`timescale 1ns/100ps
module pin_ctrl_mem (
    // clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // write port
    input wire wr_en_in,
    input wire [2:0] wr_addr_in,
    input wire [31:0] wr_data_in,
    // read port
    input wire [2:0] rd_addr_in,
    output reg [31:0] rd_data_out,
    // all pin enable bits at once
    output wire [7:0] pin_en_out
);
    reg [31:0] mem_q [0:7];
    genvar g;

    // each word resets to zero, reserved bits 7:1 never stored
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_word
            always @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    mem_q[g] <= 32'h0000_0000;
                end else if (wr_en_in && wr_addr_in == g) begin
                    mem_q[g] <= {wr_data_in[31:8], 7'h00, wr_data_in[0]};
                end
            end
            assign pin_en_out[g] = mem_q[g][0];
        end
    endgenerate

    // registered read
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= 32'h0000_0000;
        end else begin
            rd_data_out <= mem_q[rd_addr_in];
        end
    end
endmodule // pin_ctrl_mem

// File: core/sample_format.v
// left-aligns a 12-bit conversion result into the selected sample width
`timescale 1ns/100ps
`include "adc_pkt_map.vh"
module sample_format (
    // inputs
    input wire [11:0] result_in,
    input wire [1:0] width_in,
    // formatted word, valid bytes at the top, and byte count
    output reg [31:0] word_out,
    output reg [2:0] nbytes_out
);
    // msb of the result always lands in bit 31
    always @* begin
        word_out = 32'h0000_0000;
        nbytes_out = 3'h4;
        case (width_in)
            `WIDTH_8: begin
                word_out = {result_in[11:4], 24'h000000};
                nbytes_out = 3'h1;
            end
            `WIDTH_16: begin
                word_out = {result_in, 4'h0, 16'h0000};
                nbytes_out = 3'h2;
            end
            default: begin
                word_out = {result_in, 20'h00000};
                nbytes_out = 3'h4;
            end
        endcase
    end
endmodule // sample_format

// File: testbench/adc_pkt_ctrl_bench.sv
// self-checking bench for the converter packetiser
`timescale 1ns/100ps
module adc_pkt_ctrl_bench;
    reg mclk_in = 1'b0;
    reg rstn_in = 1'b0;
    reg psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, trigger_in = 1'b0, result_valid_in = 1'b0;
    reg [7:0] paddr_in = 8'h00;
    reg [31:0] pwdata_in = 32'h0;
    reg [2:0] result_pin_in = 3'h0;
    reg [11:0] result_in = 12'h000;
    reg stall = 1'b0, fast = 1'b1;
    wire [31:0] prdata_out;
    wire pready_out, pslverr_out, conv_enable_out, calib_ref_sel_out, tx_valid_out, tx_end_out, tx_ready_in, irq_out;
    wire [7:0] pin_enable_out, tx_data_out;
    wire [23:0] tx_dest_out;
    logic [31:0] exp_q[$];
    logic [31:0] rdat;
    logic err;
    logic [11:0] v;
    logic [1:0] wcode [3] = '{2'h0, 2'h1, 2'h3};
    integer error_cnt = 0, compares = 0, ends = 0, ends_exp = 0, i;
    always #12.5 mclk_in = !mclk_in;
    adc_pkt_ctrl i_adc_pkt_ctrl (.mclk_in(mclk_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .trigger_in(trigger_in),
        .result_valid_in(result_valid_in), .result_pin_in(result_pin_in), .result_in(result_in),
        .conv_enable_out(conv_enable_out), .calib_ref_sel_out(calib_ref_sel_out), .pin_enable_out(pin_enable_out),
        .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out), .tx_end_out(tx_end_out),
        .tx_dest_out(tx_dest_out), .tx_ready_in(tx_ready_in), .irq_out(irq_out));
    chan_end_sink i_chan_end_sink (.mclk_in(mclk_in), .rstn_in(rstn_in), .stall_in(stall), .fast_in(fast),
        .tx_ready_out(tx_ready_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want) begin
            $display("unexpected at %0t: got %h want %h", $time, got, want);
            error_cnt++;
        end
    endtask
    task close_out;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task timeout;
        error_cnt++;
        close_out();
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        integer n;
        @(posedge mclk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        if (pready_out !== 1'b1) timeout();
        rdat = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        apb(1'b0, a, 32'h0);
        chk(rdat, want);
    endtask
    task automatic trig;
        @(posedge mclk_in);
        trigger_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        trigger_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
    endtask
    task automatic res(input logic [2:0] p);
        @(posedge mclk_in);
        v = 12'($urandom);
        result_valid_in <= 1'b1;
        result_pin_in <= p;
        result_in <= v;
        @(posedge mclk_in);
        result_valid_in <= 1'b0;
    endtask
    // expected bytes of the latest result, top byte first
    task automatic expect_smp(input logic [1:0] w);
        logic [31:0] word;
        integer nb;
        word = (w == 2'h0) ? {v[11:4], 24'h0} : {v, 20'h0};
        nb = (w == 2'h0) ? 1 : (w == 2'h1) ? 2 : 4;
        for (int k = 0; k < nb; k++) begin
            exp_q.push_back({24'habcdef, word[31 - 8 * k -: 8]});
        end
    endtask
    task automatic drain;
        integer n;
        n = 0;
        while ((exp_q.size() != 0 || tx_valid_out !== 1'b0) && n < 300) begin
            @(posedge mclk_in);
            n++;
        end
        if (n >= 300) timeout();
        repeat (3) @(posedge mclk_in);
    endtask
    // watcher: each accepted byte against the oldest note
    always @(posedge mclk_in) begin
        if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1) begin
            if (exp_q.size() == 0)
                chk({tx_dest_out, tx_data_out}, 32'hxxxxxxxx);
            else
                chk({tx_dest_out, tx_data_out}, exp_q.pop_front());
        end
        if (tx_end_out === 1'b1) ends++;
    end
    // ----
    // main sequence
    // ----
    initial begin
        void'($urandom(32'h9cd5));
        repeat (16) @(posedge mclk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        rd(8'h20, 32'h00010100);
        rd(8'h08, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
        wr(8'h08, 32'habcdef01);
        wr(8'h00, 32'h12345601);
        wr(8'h20, 32'h00010101);
        wr(8'h00, 32'h0);
        rd(8'h08, 32'habcdef01);
        rd(8'h00, 32'h12345601);
        wr(8'h20, 32'h00010103);
        wr(8'h20, 32'h00010101);
        for (i = 0; i < 6; i++) begin
            trig();
            res(3'h2);
        end
        trig();
        $display("test calibration done");
        for (i = 0; i < 3; i++) begin
            fast <= (i != 2);
            wr(8'h20, {14'h0, wcode[i], 16'h0101});
            res(3'h5);
            res(3'h2);
            expect_smp(wcode[i]);
            ends_exp++;
            drain();
        end
        wr(8'h20, 32'h00010201);
        for (i = 0; i < 2; i++) begin
            res(3'h2);
            expect_smp(2'h1);
            repeat (4) @(posedge mclk_in);
        end
        ends_exp++;
        drain();
        chk(ends, ends_exp);
        $display("test widths done");
        wr(8'h20, 32'h00010101);
        stall <= 1'b1;
        res(3'h2);
        expect_smp(2'h1);
        repeat (4) @(posedge mclk_in);
        res(3'h2);
        expect_smp(2'h1);
        res(3'h2);
        stall <= 1'b0;
        ends_exp += 2;
        drain();
        rd(8'h20, 32'h01010101);
        rd(8'h20, 32'h00010101);
        chk({31'h0, irq_out}, 32'h0);
        wr(8'h28, 32'h1);
        repeat (2) @(posedge mclk_in);
        chk({31'h0, irq_out}, 32'h1);
        wr(8'h24, 32'h3);
        repeat (2) @(posedge mclk_in);
        chk({31'h0, irq_out}, 32'h0);
        rd(8'h24, 32'h0);
        $display("test drop done");
        wr(8'h20, 32'h00010001);
        res(3'h2);
        expect_smp(2'h1);
        drain();
        chk(ends, ends_exp);
        rd(8'h08, 32'habcdef01);
        ends_exp++;
        repeat (3) @(posedge mclk_in);
        chk(ends, ends_exp);
        $display("test open packet done");
        close_out();
    end
endmodule // adc_pkt_ctrl_bench

// File: testbench/adc_pkt_ctrl_sva.sv
// port checker for the converter packetiser
`timescale 1ns/100ps
module adc_pkt_ctrl_sva (
    // clock, reset and apb
    input wire mclk_in,
    input wire rstn_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire pready_out,
    input wire pslverr_out,
    // converter and stream
    input wire conv_enable_out,
    input wire calib_ref_sel_out,
    input wire [7:0] pin_enable_out,
    input wire [7:0] tx_data_out,
    input wire tx_valid_out,
    input wire tx_end_out,
    input wire [23:0] tx_dest_out,
    input wire tx_ready_in
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    // completed writes and accepted bytes
    wire wr_done = psel_in && penable_in && pready_out && pwrite_in;
    wire wr_gen = wr_done && paddr_in == 8'h20;
    wire wr_pin0 = wr_done && paddr_in == 8'h00;
    wire took = tx_valid_out && tx_ready_in;
    a_enable_follows: assert property (wr_gen |-> ##2 conv_enable_out == $past(pwdata_in[0], 2))
        else $error("enable output misses written bit");
    a_calib_follows: assert property (wr_gen |-> ##2 calib_ref_sel_out == $past(pwdata_in[1], 2))
        else $error("reference select misses written bit");
    a_pin_enable: assert property (wr_pin0 && !conv_enable_out |-> ##2 pin_enable_out[0] == $past(pwdata_in[0], 2))
        else $error("pin enable misses written bit");
    a_pin_locked: assert property (wr_pin0 && conv_enable_out |=> $stable(pin_enable_out) [*2])
        else $error("pin register changed while enabled");
    a_tx_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable({tx_dest_out, tx_data_out}))
        else $error("byte changed before acceptance");
    a_cal_quiet: assert property ($rose(conv_enable_out) |-> !tx_valid_out [*8])
        else $error("byte sent during calibration");
    a_end_cause: assert property (tx_end_out |-> $past(took) || $past(took, 2) || $past(psel_in, 2))
        else $error("packet end without cause");
    a_end_pulse: assert property (tx_end_out |=> !tx_end_out)
        else $error("packet end longer than one cycle");
    c_end: cover property (tx_end_out);
    c_stall: cover property (tx_valid_out && !tx_ready_in);
    c_err: cover property (pslverr_out && pready_out);
endmodule // adc_pkt_ctrl_sva

bind adc_pkt_ctrl adc_pkt_ctrl_sva i_adc_pkt_ctrl_sva (.mclk_in(mclk_in), .rstn_in(rstn_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .conv_enable_out(conv_enable_out),
    .calib_ref_sel_out(calib_ref_sel_out), .pin_enable_out(pin_enable_out), .tx_data_out(tx_data_out),
    .tx_valid_out(tx_valid_out), .tx_end_out(tx_end_out), .tx_dest_out(tx_dest_out), .tx_ready_in(tx_ready_in));

// File: testbench/chan_end_sink.sv
// channel-end byte sink pacing its ready line
`timescale 1ns/100ps
module chan_end_sink (
    // clock and reset
    input wire mclk_in,
    input wire rstn_in,
    // pacing
    input wire stall_in,
    input wire fast_in,
    // stream handshake
    output reg tx_ready_out
);
    reg [1:0] pace_q;
    // ready every cycle when fast, one in four when slow, never when stalled
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pace_q <= 2'h0;
            tx_ready_out <= 1'b0;
        end else begin
            pace_q <= pace_q + 2'h1;
            tx_ready_out <= !stall_in && (fast_in || pace_q == 2'h0);
        end
    end
endmodule // chan_end_sink
